// ==== rtl/lbd_led_driver.sv ====
/*
  Three-channel LED driver: off, on, blink at a programmed duty, or breathe.
  Assumes the register port is a simple word-wide strobe port in the system
  clock domain and that the slow clock input is synchronous to SYS_CLK.
*/
// Overview of operation
// - Each blink period has 256 phases from an 8-bit counter on prescaled ticks.
// - Prescale zero uses every slow tick; value N divides the slow clock by N+1.
// - Constant off or on stops that channel's prescaler and counters.
// - Blink: output on for phases below duty, off for phases above it.
// - Blink: duty zero is always off, duty all ones is always on.
// - Breathe: effective duty rises by one each period up to all ones.
// - Then it falls by one each period to the programmed minimum, and repeats.
// - Control bits 1:0 select off, blink, breathe, on for values 0 to 3.
// - While any channel's realign bit is one, every counter holds its start value.
// - Counting resumes only when all realign bits are zero.
// - A register write reaches the output within 30 microseconds.
// - Rate register: prescale in bits 27:16, duty in 7:0, other bits read zero.
// - Three channels, register sets at base, base plus 80h and base plus 100h.
// - Counters run on the system clock and step on slow clock ticks; the register port only accesses registers.
// - The block raises no interrupt request.
`timescale 1ns/10ps
`default_nettype none

module lbd_led_driver (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic SRST,
  // Slow crystal clock, sampled as a level.
  input wire logic SLOW_CRYSTAL_CLOCK,
  // Register port.
  input wire logic [8:0] BUS_ADDR,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [3:0] BUS_BE,
  input wire logic [31:0] BUS_WDATA,
  output logic [31:0] BUS_RDATA,
  // LED drives; there is no request line towards the controller.
  output logic [2:0] LED_OUT
);

  localparam int WR_LAT_MAX = 2;

  lbd_pkg::lbd_state_t s_r;
  lbd_pkg::lbd_state_t s_nxt;
  logic any_sync;
  logic tick;
  logic step;
  logic [31:0] rd;
  lbd_pkg::lbd_mode_t mode;

  function automatic logic reg_hit(input logic [8:0] a, input logic [1:0] inst,
                                   input logic [8:0] ofs);
    reg_hit = (a == 9'(lbd_pkg::INST_STRIDE * inst + ofs));
  endfunction

  always_comb begin
    s_nxt = s_r;
    any_sync = 1'b0;
    tick = 1'b0;
    step = 1'b0;
    rd = 32'h00000000;
    mode = lbd_pkg::MODE_OFF;
    // The slow clock is only sampled; its rising edge is a one-cycle tick.
    s_nxt.slow_q = SLOW_CRYSTAL_CLOCK;
    tick = SLOW_CRYSTAL_CLOCK & ~s_r.slow_q;
    for (int i = 0; i < lbd_pkg::NUM_INST; i++) begin
      any_sync = any_sync | s_r.ctrl[i][lbd_pkg::SYNC_BIT];
    end
    for (int i = 0; i < lbd_pkg::NUM_INST; i++) begin
      // A whole field is taken in one edge when all of its byte lanes are enabled, so the counters never see half of it.
      if (BUS_WR && BUS_BE[0] && reg_hit(BUS_ADDR, 2'(i), lbd_pkg::CTRL_OFS)) begin
        s_nxt.ctrl[i] = BUS_WDATA[2:0];
      end
      if (BUS_WR && reg_hit(BUS_ADDR, 2'(i), lbd_pkg::RATE_OFS)) begin
        if (BUS_BE[0]) begin
          s_nxt.duty[i] = BUS_WDATA[7:0];
        end
        if (BUS_BE[2]) begin
          s_nxt.div[i][7:0] = BUS_WDATA[23:16];
        end
        if (BUS_BE[3]) begin
          s_nxt.div[i][11:8] = BUS_WDATA[27:24];
        end
      end
      if (reg_hit(BUS_ADDR, 2'(i), lbd_pkg::CTRL_OFS)) begin
        rd = {29'h00000000, s_r.ctrl[i]};
      end
      if (reg_hit(BUS_ADDR, 2'(i), lbd_pkg::RATE_OFS)) begin
        rd = {4'h0, s_r.div[i], 8'h00, s_r.duty[i]};
      end

      mode = lbd_pkg::lbd_mode_t'(s_r.ctrl[i][1:0]);
      step = tick && (s_r.presc[i] >= s_r.div[i]);
      if (mode == lbd_pkg::MODE_OFF || mode == lbd_pkg::MODE_ON || any_sync) begin
        // Idle channels keep their counters parked, which also saves power.
        s_nxt.presc[i] = 12'h000;
        s_nxt.phase[i] = 8'h00;
        s_nxt.eff[i] = s_r.duty[i];
        s_nxt.down[i] = 1'b0;
      end else if (tick) begin
        if (step) begin
          s_nxt.presc[i] = 12'h000;
          s_nxt.phase[i] = s_r.phase[i] + 8'h01;
        end else begin
          s_nxt.presc[i] = s_r.presc[i] + 12'h001;
        end
        if (step && s_r.phase[i] == lbd_pkg::PHASE_LAST) begin
          if (!s_r.down[i]) begin
            if (s_r.eff[i] != lbd_pkg::DUTY_FULL) begin
              s_nxt.eff[i] = s_r.eff[i] + 8'h01;
            end
            // A minimum of all ones leaves nothing to fall back to.
            if ((s_r.eff[i] + 8'h01 == lbd_pkg::DUTY_FULL ||
                 s_r.eff[i] == lbd_pkg::DUTY_FULL) && s_r.duty[i] != lbd_pkg::DUTY_FULL) begin
              s_nxt.down[i] = 1'b1;
            end
          end else begin
            if (s_r.eff[i] > s_r.duty[i]) begin
              s_nxt.eff[i] = s_r.eff[i] - 8'h01;
            end
            if (s_r.eff[i] <= s_r.duty[i] + 8'h01) begin
              s_nxt.down[i] = 1'b0;
            end
          end
        end
      end

      // The output follows registers every system cycle, far inside the allowed latency.
      case (mode)
        lbd_pkg::MODE_OFF: begin
          s_nxt.led[i] = 1'b0;
        end
        lbd_pkg::MODE_ON: begin
          s_nxt.led[i] = 1'b1;
        end
        lbd_pkg::MODE_BLINK: begin
          s_nxt.led[i] = (s_r.duty[i] == lbd_pkg::DUTY_FULL) ||
                         (s_r.phase[i] < s_r.duty[i]);
        end
        lbd_pkg::MODE_BREATHE: begin
          s_nxt.led[i] = (s_r.eff[i] == lbd_pkg::DUTY_FULL) ||
                         (s_r.phase[i] < s_r.eff[i]);
        end
        default: begin
          s_nxt.led[i] = 1'b0;
        end
      endcase
    end
    s_nxt.rdata = BUS_RD ? rd : 32'h00000000;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      s_r <= '0;
      for (int i = 0; i < lbd_pkg::NUM_INST; i++) begin
        s_r.ctrl[i] <= lbd_pkg::CTRL_RST;
        s_r.div[i] <= lbd_pkg::DIV_RST;
        s_r.duty[i] <= lbd_pkg::DUTY_RST;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  assign BUS_RDATA = s_r.rdata;
  assign LED_OUT = s_r.led;

  // Checks on channel 0, plus realign and register checks on channels 1 and 2; the three channels share one body of logic.
  logic run0;
  logic step0;
  assign run0 = (s_r.ctrl[0][1:0] == 2'h1 || s_r.ctrl[0][1:0] == 2'h2) && !any_sync;
  assign step0 = run0 && tick && (s_r.presc[0] >= s_r.div[0]);

  AST_OFF_DARK: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][1:0] == 2'h0) |=> !LED_OUT[0])
    else $error("Channel 0 lit while set to off.");

  AST_STATIC_PARK: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][1:0] == 2'h3) |=> (s_r.presc[0] == 12'h000 && s_r.phase[0] == 8'h00))
    else $error("Counters of a constant-on channel still running.");

  AST_SYNC_HOLD: assert property (@(posedge SYS_CLK) disable iff (SRST)
    any_sync |=> (s_r.phase == '0 && s_r.presc == '0))
    else $error("Counters moved while realign is set.");

  AST_PHASE_STEP: assert property (@(posedge SYS_CLK) disable iff (SRST)
    step0 |=> (s_r.phase[0] == $past(s_r.phase[0]) + 8'h01))
    else $error("Phase did not advance on a prescaled tick.");

  AST_PRESC_WAIT: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (run0 && tick && s_r.presc[0] < s_r.div[0]) |=> $stable(s_r.phase[0]))
    else $error("Phase advanced before the prescaler expired.");

  AST_BLINK_CMP: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][1:0] == 2'h1 && s_r.duty[0] != 8'hFF)
    |=> (LED_OUT[0] == ($past(s_r.phase[0]) < $past(s_r.duty[0]))))
    else $error("Blink output disagrees with phase against duty.");

  AST_DUTY_ZERO: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][1:0] == 2'h1 && s_r.duty[0] == 8'h00) [*2] |-> !LED_OUT[0])
    else $error("Blink with zero duty produced light.");

  AST_BREATHE_UP: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (step0 && s_r.ctrl[0][1:0] == 2'h2 && s_r.phase[0] == 8'hFF && !s_r.down[0] &&
     s_r.eff[0] != 8'hFF) |=> (s_r.eff[0] == $past(s_r.eff[0]) + 8'h01))
    else $error("Breathe duty did not rise at the period end.");

  AST_BREATHE_FLOOR: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (step0 && s_r.ctrl[0][1:0] == 2'h2 && s_r.phase[0] == 8'hFF && s_r.down[0] &&
     s_r.eff[0] > s_r.duty[0]) |=> (s_r.eff[0] == $past(s_r.eff[0]) - 8'h01))
    else $error("Breathe duty did not fall at the period end.");

  AST_WRITE_EFFECT: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (BUS_WR && BUS_BE[0] && BUS_ADDR == 9'h000 && BUS_WDATA[1:0] == 2'h3)
    |-> ##[1:WR_LAT_MAX] LED_OUT[0])
    else $error("Constant-on write did not reach the output in time.");

  AST_RSV_ZERO: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (BUS_RD && BUS_ADDR == 9'h004) |=> (BUS_RDATA[31:28] == 4'h0 && BUS_RDATA[15:8] == 8'h00))
    else $error("Reserved rate bits read nonzero.");

  AST_ON_LIT: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][1:0] == 2'h3) |=> LED_OUT[0])
    else $error("Channel 0 dark while set to constant on.");

  AST_DUTY_FULL: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][1:0] == 2'h1 && s_r.duty[0] == 8'hFF) [*2] |-> LED_OUT[0])
    else $error("Blink with full duty went dark.");

  AST_BREATHE_CMP: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][1:0] == 2'h2 && s_r.eff[0] != 8'hFF)
    |=> (LED_OUT[0] == ($past(s_r.phase[0]) < $past(s_r.eff[0]))))
    else $error("Breathe output disagrees with phase against effective duty.");

  AST_OFF_PARK: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][1:0] == 2'h0) |=> (s_r.presc[0] == 12'h000 && s_r.phase[0] == 8'h00))
    else $error("Counters of a constant-off channel still running.");

  // Realign is also checked from the raw bits, so a wrong any_sync cannot excuse itself.
  AST_SYNC_ALL: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][2] || s_r.ctrl[1][2] || s_r.ctrl[2][2])
    |=> (s_r.phase == '0 && s_r.presc == '0))
    else $error("A realign bit failed to hold every counter.");

  AST_SYNC_EFF: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][2] || s_r.ctrl[1][2] || s_r.ctrl[2][2])
    |=> (s_r.eff == $past(s_r.duty) && s_r.down == 3'h0))
    else $error("Breathe state left its start value during realign.");

  AST_RESUME: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][1:0] == 2'h1 && s_r.ctrl[0][2] == 1'b0 && s_r.ctrl[1][2] == 1'b0 &&
     s_r.ctrl[2][2] == 1'b0 && tick && s_r.presc[0] >= s_r.div[0])
    |=> (s_r.phase[0] == $past(s_r.phase[0]) + 8'h01))
    else $error("Blink phase stalled with every realign bit clear.");

  AST_IDLE_HOLD: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (run0 && !tick) |=> ($stable(s_r.phase[0]) && $stable(s_r.presc[0])))
    else $error("Counters moved without a slow clock tick.");

  AST_STEP_CLEAR: assert property (@(posedge SYS_CLK) disable iff (SRST)
    step0 |=> (s_r.presc[0] == 12'h000))
    else $error("Prescaler not cleared when the phase advanced.");

  AST_PRESC_COUNT: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (run0 && tick && s_r.presc[0] < s_r.div[0]) |=> (s_r.presc[0] == $past(s_r.presc[0]) + 12'h001))
    else $error("Prescaler did not count a slow clock tick.");

  // Address checks decode from the bus itself, so a broken decoder cannot hide behind reg_hit.
  AST_CH1_SELECT: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (BUS_WR && BUS_BE[0] && BUS_ADDR == 9'h080) |=> (s_r.ctrl[1] == $past(BUS_WDATA[2:0])))
    else $error("Channel 1 control write did not land.");

  AST_CH2_SELECT: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (BUS_WR && BUS_BE[0] && BUS_ADDR == 9'h100) |=> (s_r.ctrl[2] == $past(BUS_WDATA[2:0])))
    else $error("Channel 2 control write did not land.");

  AST_RATE_LOAD: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (BUS_WR && BUS_BE == 4'hF && BUS_ADDR == 9'h004)
    |=> (s_r.duty[0] == $past(BUS_WDATA[7:0]) && s_r.div[0] == $past(BUS_WDATA[27:16])))
    else $error("Rate fields of channel 0 not loaded from the write.");

  AST_RATE_LANE: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (BUS_WR && BUS_BE == 4'h1 && BUS_ADDR == 9'h104) |=> $stable(s_r.div[2]))
    else $error("Prescale changed by a write without its byte lanes.");

  AST_RDATA_IDLE: assert property (@(posedge SYS_CLK) disable iff (SRST)
    !BUS_RD |=> (BUS_RDATA == 32'h00000000))
    else $error("Read data not zero outside a read.");

  AST_CTRL_RSV: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (BUS_RD && BUS_ADDR == 9'h000) |=> (BUS_RDATA[31:3] == 29'h0000000))
    else $error("Reserved control bits read nonzero.");

  COV_BLINK_TOGGLE: cover property (@(posedge SYS_CLK) disable iff (SRST)
    (s_r.ctrl[0][1:0] == 2'h1) && $rose(LED_OUT[0]));
  COV_BREATHE_TURN: cover property (@(posedge SYS_CLK) disable iff (SRST)
    $rose(s_r.down[0]));
  COV_BREATHE_FLOOR: cover property (@(posedge SYS_CLK) disable iff (SRST)
    $fell(s_r.down[0]));
  COV_REALIGN: cover property (@(posedge SYS_CLK) disable iff (SRST)
    $fell(any_sync));

endmodule

`default_nettype wire

// ==== rtl/lbd_pkg.sv ====
/*
  Shared constants and types for the three-channel LED blink and breathe driver.
  Assumes a single 40 MHz system clock; the 32.768 kHz slow clock arrives as a
  plain input that is already synchronous to it.
*/
`default_nettype none

package lbd_pkg;

  // Register map, byte offsets within one channel and channel spacing.
  localparam logic [8:0] CTRL_OFS = 9'h000;
  localparam logic [8:0] RATE_OFS = 9'h004;
  localparam logic [8:0] INST_STRIDE = 9'h080;
  localparam int NUM_INST = 3;

  // Field positions.
  localparam int MODE_LSB = 0;
  localparam int SYNC_BIT = 2;
  localparam int DUTY_LSB = 0;
  localparam int DIV_LSB = 16;

  // Values after reset.
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [11:0] DIV_RST = 12'h000;
  localparam logic [7:0] DUTY_RST = 8'h00;

  // Phase counter limits.
  localparam logic [7:0] PHASE_LAST = 8'hFF;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_NONE = 8'h00;

  // Time for a register write to reach the outputs.
  localparam int SYS_CLK_MHZ = 40;
  localparam int WRITE_EFFECT_US = 30;
  localparam int WRITE_EFFECT_CYC = WRITE_EFFECT_US * SYS_CLK_MHZ;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_BLINK = 2'h1,
    MODE_BREATHE = 2'h2,
    MODE_ON = 2'h3
  } lbd_mode_t;

  typedef struct packed {
    logic slow_q;
    logic [2:0][2:0] ctrl;
    logic [2:0][11:0] div;
    logic [2:0][7:0] duty;
    logic [2:0][11:0] presc;
    logic [2:0][7:0] phase;
    logic [2:0][7:0] eff;
    logic [2:0] down;
    logic [2:0] led;
    logic [31:0] rdata;
  } lbd_state_t;

endpackage

`default_nettype wire

// ==== tb/lbd_led_driver_tb.sv ====
/*
  Self-checking bench for the LED driver: register map, modes, blink duty,
  prescale, realign and breathe, with one lamp model on each output.
  Assumes the slow clock may run far faster than the crystal to keep periods short.
*/
`timescale 1ns/10ps
`default_nettype none
module lbd_led_driver_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic slow = 1'b0;
  logic [8:0] addr = 9'h000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic [2:0] led;
  logic clr = 1'b0;
  logic [15:0] lit [3];
  logic [8:0] base [3] = '{9'h000, 9'h080, 9'h100};
  int bad_count = 0;
  int num_checks = 0;

  always #12.5 clk = ~clk;
  // A tick every four system cycles makes one 256-phase period 1024 cycles long.
  always #50 slow = ~slow;

  lbd_led_driver DUT (.SYS_CLK(clk), .SRST(srst), .SLOW_CRYSTAL_CLOCK(slow), .BUS_ADDR(addr),
    .BUS_WR(wr), .BUS_RD(rd), .BUS_BE(be), .BUS_WDATA(wdata), .BUS_RDATA(rdata),
    .LED_OUT(led));
  for (genvar i = 0; i < 3; i++) begin : g_lamp
    lbd_led_lamp lamp (.clk(clk), .clr(clr), .led(led[i]), .lit_cycles(lit[i]));
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [8:0] a, input logic [31:0] d, input logic [3:0] b);
    @(negedge clk);
    addr = a;
    wdata = d;
    be = b;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [8:0] a, input logic [31:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  // Windows are contiguous, so a fixed lag against the period start cancels out.
  task automatic win(input int ch, input int n, input logic [31:0] exp);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (n - 1) @(negedge clk);
    chk({16'h0000, lit[ch]}, exp);
  endtask
  task automatic wait_led(input int ch, input logic v);
    int n;
    n = 0;
    while (led[ch] !== v && n < lbd_pkg::WRITE_EFFECT_CYC) begin
      @(negedge clk);
      n++;
    end
    chk({31'h00000000, led[ch]}, {31'h00000000, v});
    if (n == lbd_pkg::WRITE_EFFECT_CYC) begin
      summarize();
    end
  endtask
  function automatic logic [31:0] on_cyc(input logic [7:0] d, input logic [31:0] tp);
    return (d == 8'hFF) ? tp * 32'h100 : tp * {24'h000000, d};
  endfunction

  logic [7:0] dl [3] = '{8'h00, 8'h40, 8'hFF};
  logic [7:0] br [6] = '{8'hFD, 8'hFE, 8'hFF, 8'hFE, 8'hFD, 8'hFE};

  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    chk({29'h00000000, led}, 32'h00000000);
    for (int c = 0; c < 3; c++) begin
      rreg(base[c] + lbd_pkg::CTRL_OFS, 32'h00000000);
      rreg(base[c] + lbd_pkg::RATE_OFS, 32'h00000000);
    end
    rreg(9'h008, 32'h00000000);
    wreg(base[1] + lbd_pkg::RATE_OFS, 32'hFFFFFFFF, 4'hF);
    rreg(base[1] + lbd_pkg::RATE_OFS, 32'h0FFF00FF);
    wreg(base[2] + lbd_pkg::RATE_OFS, 32'hFFFFFFFF, 4'h1);
    rreg(base[2] + lbd_pkg::RATE_OFS, 32'h000000FF);
    wreg(base[0], 32'h00000003, 4'hF);
    wait_led(0, 1'b1);
    wreg(base[0], 32'h00000000, 4'hF);
    wait_led(0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wreg(base[0] + lbd_pkg::RATE_OFS, {24'h000000, dl[i]}, 4'hF);
      wreg(base[0], 32'h00000001, 4'hF);
      repeat (8) @(negedge clk);
      win(0, 1024, on_cyc(dl[i], 32'h4));
    end
    rreg(base[0], 32'h00000001);
    wreg(base[1] + lbd_pkg::RATE_OFS, 32'h00010040, 4'hF);
    wreg(base[1], 32'h00000001, 4'hF);
    repeat (8) @(negedge clk);
    win(1, 2048, 32'h00000200);
    wreg(base[2], 32'h00000004, 4'hF);
    wreg(base[0] + lbd_pkg::RATE_OFS, 32'h00000080, 4'hF);
    repeat (8) @(negedge clk);
    win(0, 1024, 32'h00000400);
    wreg(base[2], 32'h00000000, 4'hF);
    repeat (8) @(negedge clk);
    win(0, 1024, 32'h00000200);
    wreg(base[2], 32'h00000004, 4'hF);
    wreg(base[0] + lbd_pkg::RATE_OFS, 32'h000000FD, 4'hF);
    wreg(base[0], 32'h00000002, 4'hF);
    wreg(base[2], 32'h00000000, 4'hF);
    repeat (8) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      win(0, 1024, on_cyc(br[i], 32'h4));
    end
    summarize();
  end
endmodule
`default_nettype wire

// ==== tb/lbd_led_lamp.sv ====
/*
  Lamp model for one LED output: counts the system cycles during which it is lit.
  Assumes the output is active high; a high clr starts a new count with this cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module lbd_led_lamp (
  // Clock and window control.
  input wire logic clk,
  input wire logic clr,
  // Drive from the block.
  input wire logic led,
  output logic [15:0] lit_cycles
);
  always_ff @(posedge clk) begin
    if (clr) begin
      lit_cycles <= {15'h0000, led};
    end else begin
      lit_cycles <= lit_cycles + {15'h0000, led};
    end
  end
endmodule
`default_nettype wire
